/* File: hdl/edbct_pkg.sv */
/*
  Package for the external data bus cycle timer: cycle timing, port
  phase positions, the request carrier and the sequencer state type.
  Assumes one oscillator clock; one count step is one clock period.
*/
// Functional notes
// (RULE1) Memory presents read data within four periods after read strobe falls.
// (RULE2) A read cycle allows the memory eight periods of access time.
// (RULE3) Read data captured no later than read strobe rising; zero hold suffices.
// (RULE4) Memory releases the bus within two periods after read strobe rises.
// (RULE5) Write data driven at least one period before write strobe falls.
// (RULE6) Write data held at least one period after write strobe rises.
// (RULE7) Input ports sampled in state five, phase two.
// (RULE8) New port outputs appear at end of state six, phase two.
// (RULE9) Port inputs valid one period before address latch strobe falls.
// (RULE10) Port inputs may change right after address latch strobe falls.
// (RULE11) Read strobe falls three periods after latch strobe falls, low six.
// (RULE12) Write strobe falls three periods after latch strobe falls, low six.
// (RULE13) Address and data ports stay stable through the cycle except turnarounds.
// (RULE14) Clock may halt at either level; sequencing resumes correctly.
package edbct_pkg;

  // ==========================================================
  // Clock period in ns, then cycle timing in clock periods
  // ==========================================================
  localparam int unsigned EDBCT_CLK_NS = 10;
  localparam logic [4:0] EDBCT_ALE_HI_END = 5'h02;   // Latch strobe high 0..1
  localparam logic [4:0] EDBCT_STB_ON = 5'h05;       // Latch falls at 2, strobe at 2+3
  localparam logic [4:0] EDBCT_STB_OFF = 5'h0b;      // Strobe low six periods
  localparam logic [4:0] EDBCT_DATA_ON = 5'h03;      // Write data one period early+
  localparam logic [4:0] EDBCT_CYC_LAST = 5'h0c;     // Data held one period after
  localparam logic [4:0] EDBCT_ACCESS = 5'h08;       // Total memory access time
  localparam logic [4:0] EDBCT_RD_VALID = 5'h04;     // Memory data valid after fall

  // ==========================================================
  // Machine state phases: 12 periods, six states of two phases
  // ==========================================================
  localparam logic [3:0] EDBCT_MC_LAST = 4'hb;
  localparam logic [3:0] EDBCT_STATE5_PHASE2 = 4'h9;
  localparam logic [3:0] EDBCT_STATE6_PHASE2 = 4'hb;

  typedef struct packed {
    logic        wr;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } edbct_req_s;

  typedef enum logic [1:0] {EDBCT_IDLE, EDBCT_RUN} edbct_st_e;

endpackage

/* File: hdl/edbct_port_reg.sv */
/*
  Port phase unit: samples input pins in state five phase two and
  updates output pins at the end of state six phase two.
  Assumes the caller supplies the phase count of the machine cycle.
*/
`timescale 1ns/10ps
module edbct_port_reg
  import edbct_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [3:0] phase,
  input wire logic [7:0] pin_in,
  input wire logic [7:0] out_val,
  output logic [7:0] pin_sampled,
  output logic [7:0] pin_out
);

  logic [7:0] s1_r, s2_r, s3_r, smp_r, smp_nxt, out_r, out_nxt;

  // ==========================================================
  // Three-stage synchroniser; a change counts when 2 and 3 agree
  // ==========================================================
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_r <= 8'h00;
      s2_r <= 8'h00;
      s3_r <= 8'h00;
    end else begin
      s1_r <= pin_in;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_comb begin
    smp_nxt = smp_r;
    out_nxt = out_r;
    for (int i = 0; i < 8; i++) begin
      if (phase == EDBCT_STATE5_PHASE2 && s2_r[i] == s3_r[i]) begin
        smp_nxt[i] = s3_r[i];  // RULE7
      end
    end
    if (phase == EDBCT_STATE6_PHASE2) begin
      out_nxt = out_val;  // RULE8
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      smp_r <= 8'h00;
      out_r <= 8'hff;
    end else begin
      smp_r <= smp_nxt;
      out_r <= out_nxt;
    end
  end

  assign pin_sampled = smp_r;
  assign pin_out = out_r;

  a_out_phase: assert property (@(posedge clk) disable iff (!arst_n) // RULE8
    $changed(out_r) |-> $past(phase) == EDBCT_STATE6_PHASE2)
    else $error("port output changed outside state six phase two");

endmodule // edbct_port_reg

/* File: hdl/edbct_top.sv */
/*
  External data bus cycle timer: runs one external data read or write
  cycle on the multiplexed bus and times the general port phases.
  Assumes a static memory behind an address latch; the clock may stop.
*/
`timescale 1ns/10ps
module edbct_top
  import edbct_pkg::*;
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic req_valid,
  input wire edbct_req_s req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [7:0] rsp_rdata,
  output logic ale,
  output logic rd_n,
  output logic wr_n,
  output logic [7:0] low_addr_data_port_o,
  output logic low_addr_data_port_oe,
  input wire logic [7:0] low_addr_data_port_i,
  output logic [7:0] high_addr_port,
  input wire logic [7:0] gp_port_i,
  input wire logic [7:0] gp_port_out_val,
  output logic [7:0] gp_port_o,
  output logic [7:0] gp_port_sampled
);

  // ==========================================================
  // Cycle sequencer
  // ==========================================================
  // Fully static: every state is held in flops with no timeouts, so
  // a halted clock merely freezes the cycle where it stands.
  edbct_st_e st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  edbct_req_s cur_r, cur_nxt;
  logic [7:0] rdat_r, rdat_nxt;
  logic rsp_r, rsp_nxt;
  logic [3:0] ph_r, ph_nxt;
  logic [7:0] d1_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    cur_nxt = cur_r;
    rdat_nxt = rdat_r;
    rsp_nxt = 1'b0;
    unique case (st_r)
      EDBCT_IDLE: begin
        if (req_valid) begin
          st_nxt = EDBCT_RUN;
          cur_nxt = req;
          cnt_nxt = 5'h00;
        end
      end
      EDBCT_RUN: begin
        cnt_nxt = cnt_r + 5'h01;  // RULE14
        // Capture the registered bus while strobe still low
        if (!cur_r.wr && cnt_r == EDBCT_STB_OFF - 5'h01) begin
          rdat_nxt = d1_r;  // RULE3
        end
        if (cnt_r == EDBCT_CYC_LAST) begin
          st_nxt = EDBCT_IDLE;
          rsp_nxt = 1'b1;
        end
      end
    endcase
    ph_nxt = (ph_r == EDBCT_MC_LAST) ? 4'h0 : ph_r + 4'h1;
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= EDBCT_IDLE;
      cnt_r <= 5'h00;
      cur_r <= '0;
      rdat_r <= 8'h00;
      rsp_r <= 1'b0;
      ph_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      cur_r <= cur_nxt;
      rdat_r <= rdat_nxt;
      rsp_r <= rsp_nxt;
      ph_r <= ph_nxt;
    end
  end

  // Bus data answers our own strobes, so one input register is enough;
  // a longer pipe would sample before late memory data is due.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      d1_r <= 8'h00;
    end else begin
      d1_r <= low_addr_data_port_i;  // RULE1
    end
  end

  // ==========================================================
  // Pin outputs, registered
  // ==========================================================
  logic run, ale_nxt, rd_nxt, wr_nxt, oe_nxt;
  logic [7:0] ad_nxt, ha_nxt;
  logic ale_r, rd_r, wr_r, oe_r;
  logic [7:0] ad_r, ha_r;

  always_comb begin
    run = (st_nxt == EDBCT_RUN);
    ale_nxt = run && cnt_nxt < EDBCT_ALE_HI_END;
    rd_nxt = !(run && !cur_nxt.wr && cnt_nxt >= EDBCT_STB_ON && cnt_nxt < EDBCT_STB_OFF);  // RULE11 RULE2
    wr_nxt = !(run && cur_nxt.wr && cnt_nxt >= EDBCT_STB_ON && cnt_nxt < EDBCT_STB_OFF);   // RULE12
    // Address on the low port, then released for reads or write data
    // from one period after the latch falls until one after strobe rises.
    oe_nxt = run && (cnt_nxt < EDBCT_ALE_HI_END + 5'h01 ||
                     (cur_nxt.wr && cnt_nxt >= EDBCT_DATA_ON));  // RULE5 RULE6
    ad_nxt = (run && cnt_nxt >= EDBCT_DATA_ON) ? cur_nxt.wdata : cur_nxt.addr[7:0];
    ha_nxt = run ? cur_nxt.addr[15:8] : ha_r;  // RULE13
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ale_r <= 1'b0;
      rd_r <= 1'b1;
      wr_r <= 1'b1;
      oe_r <= 1'b0;
      ad_r <= 8'h00;
      ha_r <= 8'h00;
    end else begin
      ale_r <= ale_nxt;
      rd_r <= rd_nxt;
      wr_r <= wr_nxt;
      oe_r <= oe_nxt;
      ad_r <= ad_nxt;
      ha_r <= ha_nxt;
    end
  end

  assign ale = ale_r;
  assign rd_n = rd_r;
  assign wr_n = wr_r;
  assign low_addr_data_port_oe = oe_r;
  assign low_addr_data_port_o = ad_r;
  assign high_addr_port = ha_r;
  assign req_ready = (st_r == EDBCT_IDLE);
  assign rsp_valid = rsp_r;
  assign rsp_rdata = rdat_r;

  edbct_port_reg u_port (
    .clk(clk),
    .arst_n(arst_n),
    .phase(ph_r),
    .pin_in(gp_port_i),
    .out_val(gp_port_out_val),
    .pin_sampled(gp_port_sampled),
    .pin_out(gp_port_o)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  sequence s_ale_fall;
    $fell(ale_r);
  endsequence
  sequence s_rd_low6;
    !rd_r [*6] ##1 rd_r;
  endsequence

  a_rd_delay: assert property (@(posedge clk) disable iff (!arst_n) // RULE11
    s_ale_fall and !cur_r.wr |-> ##3 s_rd_low6)
    else $error("read strobe not three after latch fall for six");
  a_wr_delay: assert property (@(posedge clk) disable iff (!arst_n) // RULE12
    $fell(ale_r) && cur_r.wr |-> ##3 (!wr_r [*6] ##1 wr_r))
    else $error("write strobe not three after latch fall for six");
  a_wr_setup: assert property (@(posedge clk) disable iff (!arst_n) // RULE5
    $fell(wr_r) |-> $past(oe_r) && $past(ad_r) == ad_r && ad_r == cur_r.wdata)
    else $error("write data not set up before strobe");
  a_wr_hold: assert property (@(posedge clk) disable iff (!arst_n) // RULE6
    $rose(wr_r) |-> oe_r && $stable(ad_r) ##1 oe_r && $stable(ad_r))
    else $error("write data not held after strobe");
  a_rd_capture: assert property (@(posedge clk) disable iff (!arst_n) // RULE3
    $rose(rd_r) |-> !$past(rd_r, 2) && rdat_r == $past(low_addr_data_port_i, 2))
    else $error("read data not captured before strobe rise");
  a_rd_access: assert property (@(posedge clk) disable iff (!arst_n) // RULE2
    $fell(ale_r) && !cur_r.wr |-> ##(EDBCT_ACCESS + 1) $rose(rd_r))
    else $error("read access time is not eight periods");
  a_addr_stable: assert property (@(posedge clk) disable iff (!arst_n) // RULE13
    st_r == EDBCT_RUN && $past(st_r) == EDBCT_RUN |-> $stable(ha_r))
    else $error("high address moved during cycle");
  a_rd_release: assert property (@(posedge clk) disable iff (!arst_n) // RULE4
    !cur_r.wr && st_r == EDBCT_RUN && !ale_r && cnt_r > EDBCT_ALE_HI_END |-> !oe_r)
    else $error("device drives bus during read");
  a_port_sample: assert property (@(posedge clk) disable iff (!arst_n) // RULE7
    $changed(gp_port_sampled) |-> $past(ph_r) == EDBCT_STATE5_PHASE2)
    else $error("port sampled outside state five phase two");

endmodule // edbct_top

/* File: tb/edbct_mem_model.sv */
/*
  Partner model: static data memory behind an address latch on the shared bus.
  Assumes the bench resolves the bus from the device enable and mem_o.
*/
`timescale 1ns/10ps
module edbct_mem_model (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [7:0] bus,
  input wire logic [7:0] high_addr_port,
  input wire logic [2:0] acc_dly,
  output logic [7:0] mem_o
);
  // ==========================================================
  // Latch, array and data drive
  // ==========================================================
  logic [7:0] mem [0:255];
  logic [7:0] lat_r;
  logic ale_r;
  logic rd_r;
  logic wr_r;
  logic [3:0] cnt_r;

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ale_r <= 1'b0;
      rd_r <= 1'b1;
      wr_r <= 1'b1;
      cnt_r <= 4'h0;
      mem_o <= 8'h00;
    end else begin
      ale_r <= ale;
      rd_r <= rd_n;
      wr_r <= wr_n;
      cnt_r <= rd_n ? 4'h0 : cnt_r + 4'h1;
      if (ale_r && !ale)
        lat_r <= bus ^ high_addr_port;
      if (!rd_n && (cnt_r + 4'h1 >= {1'b0, acc_dly}))
        mem_o <= mem[lat_r];
      else if (!(rd_n && !rd_r))
        mem_o <= ~mem_o;
      if (wr_n && !wr_r)
        mem[lat_r] <= bus;
    end
  end
endmodule // edbct_mem_model

/* File: tb/testbench.sv */
/*
  Testbench for the bus cycle timer: cycle walks, memory round trips,
  clock halt and general port phases.
  Assumes the memory model on the far side of the shared bus.
*/
`timescale 1ns/10ps
module testbench;
  import edbct_pkg::*;
  logic clk, arst_n, req_valid, req_ready, rsp_valid, ale, rd_n, wr_n, oe, halt;
  edbct_req_s req;
  logic [7:0] rsp_rdata, lo_o, hi, gp_i, gp_val, gp_o, gp_s, mem_o, bus;
  logic [2:0] dly;
  int fail_count, n_checks;

  // Device drives while enabled, else memory
  assign bus = oe ? lo_o : mem_o;

  edbct_top uut (.clk(clk), .arst_n(arst_n), .req_valid(req_valid), .req(req), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .low_addr_data_port_o(lo_o), .low_addr_data_port_oe(oe), .low_addr_data_port_i(bus),
    .high_addr_port(hi), .gp_port_i(gp_i), .gp_port_out_val(gp_val), .gp_port_o(gp_o),
    .gp_port_sampled(gp_s));
  edbct_mem_model mem (.clk(clk), .arst_n(arst_n), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .bus(bus),
    .high_addr_port(hi), .acc_dly(dly), .mem_o(mem_o));

  // ==========================================================
  // Clock, checks and verdict
  // ==========================================================
  initial begin
    clk = 1'b0;
    forever begin
      #(EDBCT_CLK_NS / 2);
      if (!halt) clk = ~clk;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict;
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========================================================
  // One bus cycle, strobes, enable, address and handshake judged each period
  // ==========================================================
  task automatic do_op(input logic w, input logic [15:0] a, input logic [7:0] d, input bit stall);
    int n;
    // Offer only while idle, so the next rising edge is the one that takes it
    n = 0;
    while (req_ready !== 1'b1 && n < 20) begin
      n++;
      @(negedge clk);
    end
    req_valid = 1'b1;
    req.wr = w;
    req.addr = a;
    req.wdata = d;
    @(posedge clk);
    for (n = 1; n <= 14; n++) begin
      @(negedge clk);
      req_valid = 1'b0;
      chk(ale, n <= 2);
      chk(rd_n, !(!w && n >= 6 && n <= 11));
      chk(wr_n, !(w && n >= 6 && n <= 11));
      chk(oe, n <= (w ? 13 : 3));
      if (n <= 3) chk(lo_o, a[7:0]);
      else if (w && n <= 13) chk(lo_o, d);
      chk(hi, a[15:8]);
      chk(rsp_valid, n == 14);
      chk(req_ready, n == 14);
      if (stall && n == 7) begin
        halt = 1'b1;
        #300;
        halt = 1'b0;
      end
    end
    if (!w) chk(rsp_rdata, d);
  endtask

  task automatic port_phases;
    int n;
    gp_val = 8'h3c;
    n = 0;
    while (gp_o !== 8'h3c && n < 30) begin
      @(negedge clk);
      n++;
    end
    // Input settles long before the state five phase two sample and is then left alone
    gp_val = 8'hc3;
    gp_i = 8'h96;
    n = 0;
    while (gp_s !== 8'h96 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk(n, 10);
    // Input moves right after being taken; the sampled value must not
    gp_i = 8'h69;
    while (gp_o !== 8'hc3 && n < 30) begin
      @(negedge clk);
      n++;
    end
    chk(n, 12);
    chk(gp_s, 8'h96);
  endtask

  initial begin
    #20000;
    fail_count++;
    give_verdict;
  end

  initial begin
    halt = 1'b0;
    arst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    gp_i = 8'h00;
    gp_val = 8'hff;
    dly = 3'h4;
    fail_count = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    @(negedge clk);
    chk({ale, rd_n, wr_n, oe, gp_o}, 16'h06ff);
    arst_n = 1'b1;
    do_op(1'b1, 16'h1234, 8'h5a, 1'b0);
    do_op(1'b1, 16'h00ab, 8'hc3, 1'b0);
    do_op(1'b0, 16'h1234, 8'h5a, 1'b0);
    dly = 3'h1;
    // Slow clock stop in mid strobe, memory answering promptly
    do_op(1'b0, 16'h00ab, 8'hc3, 1'b1);
    port_phases();
    give_verdict;
  end
endmodule // testbench
